// file: rtl/acsq_sequencer.sv
// How it works
// - Reference bit clear: drive internal reference out
// - Reference bit set: pin input, reference off
// - Inhibit level picks polarity; active stalls acquisition
// - Settle code gives 1/256/2048/16384 clocks
// - Settle also before X/Y and after last
// - Inhibit ignored during settle delay
// - Power code 00 keeps converter off always
// - Code 01: converter and reference off idle
// - Code 10: converter and reference always on
// - Code 11: only converter off when idle
// - Window code gives 4/8/16/32 clock acquisition
// - Mean code 1/4/8/16; store final only
// - Separate host and touch channel masks
// - Mask bit 11 is channel 0, downward
// - Ready low only after results written
// - Result read returns ready high
// - Timer restart returns ready high
// - Repeat timer single or 1024/2048/16384 clocks
module acsq_sequencer
    import acsq_pkg::*;
#(
    parameter logic [14:0] SETTLE_CNT3 = 15'h4000,
    parameter logic [14:0] TIMER_CNT3  = 15'h4000
) (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rstn,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Pins
    input  wire logic            sample_inhibit_in,
    input  wire logic            touch_alert_n,
    output logic                 results_ready_n,
    // Converter core
    output acsq_conv_ctrl_t      convCtrl,
    input  wire logic            convDone,
    input  wire logic [11:0]     convData
);

    acsq_state_reg_t s_reg;
    acsq_state_reg_t s_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // ascending search of mask
    function automatic logic [4:0] findChan(input logic [11:0] mask, input logic [4:0] from);
        logic [4:0] res;
        res = 5'h1f;
        for (int c = NUM_CHAN - 1; c >= 0; c--) begin
            if (5'(c) >= from && mask[11 - c]) begin
                res = 5'(c);
            end
        end
        return res;
    endfunction : findChan

    function automatic logic [14:0] settleCnt(input logic [1:0] sel);
        case (sel)
            2'h0:    return SETTLE_CNT0;
            2'h1:    return SETTLE_CNT1;
            2'h2:    return SETTLE_CNT2;
            default: return SETTLE_CNT3;
        endcase
    endfunction : settleCnt

    function automatic logic [14:0] timerCnt(input logic [1:0] sel);
        case (sel)
            2'h1:    return TIMER_CNT1;
            2'h2:    return TIMER_CNT2;
            default: return TIMER_CNT3;
        endcase
    endfunction : timerCnt

    logic [1:0]  timerSel;
    logic [1:0]  settleSel;
    logic [1:0]  powerSel;
    logic [1:0]  windowSel;
    logic [1:0]  meanSel;
    logic        refExternal;
    logic        inhibitActive;
    logic        touched;
    logic [11:0] activeMask;
    logic [14:0] windowCnt;
    logic [4:0]  meanCnt;
    logic [15:0] meanVal;
    logic [15:0] lastSum;
    logic [4:0]  nextChan;
    logic [4:0] firstHost;
    logic [4:0] firstTouch;
    logic        busy;
    logic [7:0]  resIdx;

    always_comb begin
        timerSel    = s_reg.setup[TIMER_LSB +: 2];
        settleSel   = s_reg.setup[SETTLE_LSB +: 2];
        powerSel    = s_reg.setup[POWER_LSB +: 2];
        windowSel   = s_reg.setup[WINDOW_LSB +: 2];
        meanSel     = s_reg.setup[MEAN_LSB +: 2];
        refExternal = s_reg.setup[REF_BIT];
        inhibitActive = (s_reg.inhSync2 == s_reg.setup[POL_BIT]);
        touched     = !s_reg.touchSync2;
        activeMask  = s_reg.seqTouch ? s_reg.touchMask : s_reg.hostMask;
        windowCnt   = WINDOW_CNT0 << windowSel;
        meanCnt     = (meanSel == 2'h0) ? 5'd1 : 5'(5'd2 << meanSel);
        // truncated mean, including the conversion now done
        lastSum     = s_reg.sum + {4'h0, convData};
        case (meanSel)
            2'h0:    meanVal = lastSum;
            2'h1:    meanVal = lastSum >> 2;
            2'h2:    meanVal = lastSum >> 3;
            default: meanVal = lastSum >> 4;
        endcase
        nextChan   = findChan(activeMask, 5'(s_reg.chan) + 5'd1);
        firstHost  = findChan(s_reg.hostMask, 5'd0);
        firstTouch = findChan(s_reg.touchMask, 5'd0);
        resIdx     = (paddr - ADDR_RESULT0) >> 2;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_next                = s_reg;
        s_next.ctrl.convStart = 1'b0;
        s_next.pready         = 1'b1;
        s_next.inhSync1       = sample_inhibit_in;
        s_next.inhSync2       = s_reg.inhSync1;
        s_next.touchSync1     = touch_alert_n;
        s_next.touchSync2     = s_reg.touchSync1;

        // Setup phase: decode and latch read data
        if (psel && !penable) begin
            s_next.pslverr = 1'b0;
            s_next.prdata  = 32'h0;
            case (paddr)
                ADDR_MODE:       s_next.prdata = {30'h0, s_reg.mode};
                ADDR_SETUP:      s_next.prdata = {20'h0, s_reg.setup};
                ADDR_HOST_MASK:  s_next.prdata = {20'h0, s_reg.hostMask};
                ADDR_TOUCH_MASK: s_next.prdata = {20'h0, s_reg.touchMask};
                ADDR_STATUS:     s_next.prdata = {26'h0, s_reg.st, s_reg.inhSync2,
                                                  s_reg.seqTouch, !s_reg.readyN};
                default: begin
                    if (paddr >= ADDR_RESULT0 && resIdx < 8'(NUM_CHAN) && paddr[1:0] == 2'h0) begin
                        s_next.prdata = {20'h0, s_reg.results[resIdx[3:0]]};
                    end else begin
                        s_next.pslverr = 1'b1;
                    end
                end
            endcase
        end

        // Access phase: writes and read side effects
        if (psel && penable && !s_reg.pslverr) begin
            if (pwrite) begin
                case (paddr)
                    ADDR_MODE:       s_next.mode      = pwdata[1:0];
                    ADDR_SETUP:      s_next.setup     = pwdata[11:0];
                    ADDR_HOST_MASK:  s_next.hostMask  = {pwdata[11:1], 1'b0};
                    ADDR_TOUCH_MASK: s_next.touchMask = {pwdata[11:1], 1'b0};
                    default: ;
                endcase
            end else if (paddr >= ADDR_RESULT0) begin
                s_next.readyN = 1'b1;
            end
        end

        // --------------------------------------------------------
        // Sequencer
        // --------------------------------------------------------
        case (s_reg.st)
            S_IDLE: begin
                if (s_reg.mode == MODE_HOST && powerSel != 2'h0 && !firstHost[4]) begin
                    s_next.seqTouch = 1'b0;
                    s_next.readyN   = 1'b1;
                    s_next.chan     = firstHost[3:0];
                    s_next.st       = S_SETTLE;
                    s_next.cnt      = settleCnt(settleSel) - 15'd1;
                end else if (s_reg.mode == MODE_TOUCH && powerSel != 2'h0 && touched
                             && !firstTouch[4]) begin
                    s_next.seqTouch = 1'b1;
                    s_next.readyN   = 1'b1;
                    s_next.chan     = firstTouch[3:0];
                    s_next.st       = S_SETTLE;
                    s_next.cnt      = settleCnt(settleSel) - 15'd1;
                end
            end
            S_SETTLE: begin
                if (s_reg.cnt == 15'd0) begin
                    s_next.st      = S_ACQ;
                    s_next.cnt     = windowCnt - 15'd1;
                    s_next.avgLeft = meanCnt;
                    s_next.sum     = 16'h0;
                end else begin
                    s_next.cnt = s_reg.cnt - 15'd1;
                end
            end
            S_ACQ: begin
                if (!inhibitActive) begin
                    if (s_reg.cnt == 15'd0) begin
                        s_next.st             = S_CONV;
                        s_next.ctrl.convStart = 1'b1;
                    end else begin
                        s_next.cnt = s_reg.cnt - 15'd1;
                    end
                end
            end
            S_CONV: begin
                if (convDone) begin
                    s_next.sum = s_reg.sum + {4'h0, convData};
                    if (s_reg.avgLeft > 5'd1) begin
                        s_next.avgLeft = s_reg.avgLeft - 5'd1;
                        s_next.st      = S_ACQ;
                        s_next.cnt     = windowCnt - 15'd1;
                    end
                end
                if (s_reg.st == S_CONV && s_next.st == S_CONV && convDone) begin
                    s_next.results[s_reg.chan] = meanVal[11:0];
                    s_next.sum                 = 16'h0;
                    if (!nextChan[4]) begin
                        s_next.chan = nextChan[3:0];
                        // extra settle before X and Y
                        if (nextChan < 5'd2) begin
                            s_next.st  = S_SETTLE;
                            s_next.cnt = settleCnt(settleSel) - 15'd1;
                        end else begin
                            s_next.st      = S_ACQ;
                            s_next.cnt     = windowCnt - 15'd1;
                            s_next.avgLeft = meanCnt;
                        end
                    end else begin
                        s_next.st  = S_POST;
                        s_next.cnt = settleCnt(settleSel) - 15'd1;
                    end
                end
            end
            S_POST: begin
                if (s_reg.cnt == 15'd0) begin
                    s_next.readyN = 1'b0;
                    if (timerSel != 2'h0 && (!s_reg.seqTouch || touched)) begin
                        s_next.st  = S_WAIT;
                        s_next.cnt = timerCnt(timerSel) - 15'd1;
                    end else if (s_reg.seqTouch) begin
                        s_next.st = S_RELEASE;
                    end else begin
                        s_next.mode = MODE_RESET;
                        s_next.st   = S_IDLE;
                    end
                end else begin
                    s_next.cnt = s_reg.cnt - 15'd1;
                end
            end
            S_WAIT: begin
                if (s_reg.seqTouch && !touched) begin
                    s_next.st = S_IDLE;
                end else if (s_reg.cnt == 15'd0) begin
                    s_next.readyN = 1'b1;
                    s_next.chan   = s_reg.seqTouch ? firstTouch[3:0] : firstHost[3:0];
                    s_next.st     = S_SETTLE;
                    s_next.cnt    = settleCnt(settleSel) - 15'd1;
                end else begin
                    s_next.cnt = s_reg.cnt - 15'd1;
                end
            end
            S_RELEASE: begin
                if (!touched) begin
                    s_next.st = S_IDLE;
                end
            end
            default: s_next.st = S_IDLE;
        endcase

        // Leaving the mode or powering down stops the sequence
        if (s_next.mode != (s_reg.seqTouch ? MODE_TOUCH : MODE_HOST) && s_reg.st != S_IDLE) begin
            s_next.st = S_IDLE;
        end
        // power code 00 overrides any mode
        if (powerSel == 2'h0) begin
            s_next.st = S_IDLE;
        end

        // --------------------------------------------------------
        // Power and reference control
        // --------------------------------------------------------
        busy = (s_next.st == S_SETTLE) || (s_next.st == S_ACQ) ||
               (s_next.st == S_CONV) || (s_next.st == S_POST);
        s_next.ctrl.adcPowerUp = (powerSel == 2'h2) || (powerSel[0] && busy);
        s_next.ctrl.refPowerUp = !refExternal &&
                                 ((powerSel == 2'h2) || (powerSel == 2'h3) ||
                                  (powerSel == 2'h1 && busy));
        s_next.ctrl.refDriveN  = refExternal;
        s_next.ctrl.sampleEn   = (s_next.st == S_ACQ) && !inhibitActive;
        s_next.ctrl.convChan   = s_next.chan;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg           <= '0;
            s_reg.st        <= S_IDLE;
            s_reg.mode      <= MODE_RESET;
            s_reg.setup     <= SETUP_RESET;
            s_reg.hostMask  <= MASK_RESET;
            s_reg.touchMask <= MASK_RESET;
            s_reg.readyN    <= 1'b1;
            s_reg.pready    <= 1'b1;
            s_reg.inhSync1  <= 1'b1;
            s_reg.inhSync2  <= 1'b1;
            s_reg.touchSync1 <= 1'b1;
            s_reg.touchSync2 <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata          = s_reg.prdata;
    assign pready          = s_reg.pready;
    assign pslverr         = s_reg.pslverr;
    assign results_ready_n = s_reg.readyN;
    assign convCtrl        = s_reg.ctrl;

endmodule : acsq_sequencer

// file: inc/acsq_pkg.sv
package acsq_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE       = 8'h00;
    localparam logic [7:0] ADDR_SETUP      = 8'h04;
    localparam logic [7:0] ADDR_HOST_MASK  = 8'h08;
    localparam logic [7:0] ADDR_TOUCH_MASK = 8'h0c;
    localparam logic [7:0] ADDR_STATUS     = 8'h10;
    localparam logic [7:0] ADDR_RESULT0    = 8'h40;
    localparam int         NUM_CHAN        = 11;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int TIMER_LSB  = 0;
    localparam int REF_BIT    = 2;
    localparam int POL_BIT    = 3;
    localparam int SETTLE_LSB = 4;
    localparam int POWER_LSB  = 6;
    localparam int WINDOW_LSB = 8;
    localparam int MEAN_LSB   = 10;
    localparam logic [11:0] SETUP_RESET = 12'h000;
    localparam logic [11:0] MASK_RESET  = 12'h000;
    localparam logic [1:0]  MODE_RESET  = 2'h0;
    localparam logic [1:0]  MODE_HOST   = 2'h2;
    localparam logic [1:0]  MODE_TOUCH  = 2'h3;

    // ------------------------------------------------------------
    // Timing counts in clock periods
    // ------------------------------------------------------------
    localparam logic [14:0] SETTLE_CNT0 = 15'h0001;
    localparam logic [14:0] SETTLE_CNT1 = 15'h0100;
    localparam logic [14:0] SETTLE_CNT2 = 15'h0800;
    localparam logic [14:0] TIMER_CNT1  = 15'h0400;
    localparam logic [14:0] TIMER_CNT2  = 15'h0800;
    localparam logic [14:0] WINDOW_CNT0 = 15'h0004;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE, S_SETTLE, S_ACQ, S_CONV, S_POST, S_WAIT, S_RELEASE
    } acsq_state_t;

    typedef struct packed {
        logic       adcPowerUp;
        logic       refPowerUp;
        logic       refDriveN;
        logic       sampleEn;
        logic       convStart;
        logic [3:0] convChan;
    } acsq_conv_ctrl_t;

    typedef struct packed {
        acsq_state_t                     st;
        logic [1:0]                      mode;
        logic [11:0]                     setup;
        logic [11:0]                     hostMask;
        logic [11:0]                     touchMask;
        logic                            seqTouch;
        logic [3:0]                      chan;
        logic [14:0]                     cnt;
        logic [4:0]                      avgLeft;
        logic [15:0]                     sum;
        logic [NUM_CHAN-1:0][11:0]       results;
        logic                            readyN;
        logic [31:0]                     prdata;
        logic                            pslverr;
        logic                            pready;
        logic                            inhSync1;
        logic                            inhSync2;
        logic                            touchSync1;
        logic                            touchSync2;
        acsq_conv_ctrl_t                 ctrl;
    } acsq_state_reg_t;

endpackage : acsq_pkg

// file: tb/acsq_conv_model.sv
module acsq_conv_model
    import acsq_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // Converter core side
    input  acsq_conv_ctrl_t  convCtrl,
    output logic             convDone,
    output logic [11:0]      convData
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Alternating fast and slow answers
    // ------------------------------------------------------------
    logic        odd;
    logic        busy;
    logic [2:0]  cnt;
    logic [11:0] val;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            odd      <= 1'b0;
            busy     <= 1'b0;
            cnt      <= 3'h0;
            val      <= 12'h000;
            convDone <= 1'b0;
        end else begin
            convDone <= 1'b0;
            if (convCtrl.convStart) begin
                busy <= 1'b1;
                cnt  <= odd ? 3'h5 : 3'h1;
                val  <= {convCtrl.convChan, 8'h00} + (odd ? 12'h003 : 12'h000);
                odd  <= !odd;
            end else if (busy && cnt == 3'h0) begin
                busy     <= 1'b0;
                convDone <= 1'b1;
            end else if (busy) begin
                cnt <= cnt - 3'h1;
            end
        end
    end

    // Data lines invalid outside the done pulse
    assign convData = convDone ? val : ~val;
endmodule : acsq_conv_model

// file: tb/acsq_sequencer_monitor.sv
module acsq_sequencer_monitor
    import acsq_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Pins and core
    input  wire logic        sample_inhibit_in,
    input  wire logic        touch_alert_n,
    input  wire logic        results_ready_n,
    input  acsq_conv_ctrl_t  convCtrl,
    input  wire logic        convDone,
    input  wire logic [11:0] convData
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic [11:0] setup_reg;
    logic [2:0]  age_reg;
    logic        setupWr;
    logic        rdRes;
    logic        settled;
    logic [1:0]  pwr;
    logic        refSel;

    assign setupWr = psel && penable && pwrite && pready && (paddr == ADDR_SETUP);
    assign rdRes   = psel && penable && !pwrite && pready && paddr >= ADDR_RESULT0
                     && paddr < 8'h6c;
    assign settled = (age_reg >= 3'h3) && !setupWr;
    assign pwr     = setup_reg[POWER_LSB+1:POWER_LSB];
    assign refSel  = setup_reg[REF_BIT];

    // Shadow of the setup word, aged after each write
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            setup_reg <= SETUP_RESET;
            age_reg   <= 3'h7;
        end else if (setupWr) begin
            setup_reg <= pwdata[11:0];
            age_reg   <= 3'h0;
        end else if (age_reg != 3'h7) begin
            age_reg <= age_reg + 3'h1;
        end
    end

    property p_ref_int;
        settled && !refSel |-> !convCtrl.refDriveN;
    endproperty
    a_ref_int: assert property (p_ref_int) else $error("internal ref not driven");
    property p_ref_off;
        settled && refSel |-> convCtrl.refDriveN && !convCtrl.refPowerUp;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("external ref not honoured");
    property p_pm_off;
        settled && pwr == 2'h0 |-> !convCtrl.adcPowerUp && !convCtrl.convStart;
    endproperty
    a_pm_off: assert property (p_pm_off) else $error("converter on with policy 0");
    property p_pm_on;
        settled && pwr == 2'h2 |-> convCtrl.adcPowerUp && (refSel || convCtrl.refPowerUp);
    endproperty
    a_pm_on: assert property (p_pm_on) else $error("power lost with policy 2");
    property p_pm_ref;
        settled && pwr == 2'h3 && !refSel |-> convCtrl.refPowerUp;
    endproperty
    a_pm_ref: assert property (p_pm_ref) else $error("reference off with policy 3");
    property p_start_power;
        convCtrl.convStart |-> convCtrl.adcPowerUp && (refSel || convCtrl.refPowerUp);
    endproperty
    a_start_power: assert property (p_start_power) else $error("start while off");
    property p_ready_read;
        rdRes && !results_ready_n |=> results_ready_n;
    endproperty
    a_ready_read: assert property (p_ready_read) else $error("ready kept after read");
    property p_ready_busy;
        convCtrl.sampleEn || convCtrl.convStart |-> results_ready_n;
    endproperty
    a_ready_busy: assert property (p_ready_busy) else $error("ready low while busy");
endmodule : acsq_sequencer_monitor

bind acsq_sequencer acsq_sequencer_monitor i_mon (.sys_clk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_inhibit_in, .touch_alert_n,
    .results_ready_n, .convCtrl, .convDone, .convData);

// file: tb/acsq_sequencer_tb.sv
module acsq_sequencer_tb
    import acsq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
    $display("ERROR %s exp %0h got %0h", nm, ex, got); end end

    logic            sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic            pwrite = 1'b0, sample_inhibit_in = 1'b1, touch_alert_n = 1'b1;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0, prdata, q;
    logic            pready, pslverr, e, results_ready_n, convDone;
    logic [11:0]     convData;
    acsq_conv_ctrl_t convCtrl;
    int              fails = 0, checks = 0, starts = 0, acqLen = 0, lastAcq = 0, n;
    logic [3:0]      chans[$];
    logic [11:0]     pmSet[3] = '{12'h084, 12'h0c0, 12'h080};
    logic [2:0]      pmExp[3] = '{3'b011, 3'b100, 3'b110};

    acsq_sequencer #(.SETTLE_CNT3(15'h0020), .TIMER_CNT3(15'h0020)) i_dut (.sys_clk, .rstn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sample_inhibit_in, .touch_alert_n, .results_ready_n, .convCtrl, .convDone, .convData);
    acsq_conv_model i_core (.sys_clk, .rstn, .convCtrl, .convDone, .convData);

    always #10 sys_clk = ~sys_clk;

    // Record starts, channels and acquisition length
    always @(posedge sys_clk) begin
        if (convCtrl.convStart === 1'b1) begin
            starts++;
            chans.push_back(convCtrl.convChan);
        end
        if (convCtrl.sampleEn === 1'b1) acqLen++;
        else if (acqLen != 0) begin
            lastAcq = acqLen;
            acqLen = 0;
        end
    end

    // ------------------------------------------------------------
    // Bus and wait tasks
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 100);
        if (k >= 100) fails++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(nm, x, q)
    endtask : rd
    task automatic wait_lvl(input logic lvl, input int lim);
        n = 0;
        while (results_ready_n !== lvl && n < lim) begin @(negedge sys_clk); n++; end
        `CHK("readyLevel", lvl, results_ready_n)
    endtask : wait_lvl
    task final_report;
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report

    initial begin
        repeat (10000) @(posedge sys_clk);
        fails++;
        final_report;
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        rd("mode", ADDR_MODE, 32'h0);
        rd("setup", ADDR_SETUP, 32'h0);
        `CHK("refDrive", 1'b0, convCtrl.refDriveN)
        `CHK("pready", 1'b1, pready)
        wr(ADDR_TOUCH_MASK, 32'hfff);
        rd("touchMask", ADDR_TOUCH_MASK, 32'hffe);
        rd("hostMask", ADDR_HOST_MASK, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 1'b1, e)
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_SETUP, {20'h0, pmSet[i]});
            repeat (4) @(posedge sys_clk);
            `CHK("power", pmExp[i], {convCtrl.refPowerUp, convCtrl.adcPowerUp, convCtrl.refDriveN})
        end
        wr(ADDR_SETUP, 32'h0);
        wr(ADDR_HOST_MASK, 32'h100);
        wr(ADDR_MODE, MODE_HOST);
        repeat (50) @(posedge sys_clk);
        `CHK("offStarts", 0, starts)
        wr(ADDR_MODE, 32'h0);
        // Three channels, mean of 4, window 8
        wr(ADDR_SETUP, 32'h580);
        wr(ADDR_HOST_MASK, 32'h902);
        wr(ADDR_MODE, MODE_HOST);
        wait_lvl(1'b0, 2000);
        `CHK("chanCount", 12, chans.size())
        foreach (chans[i]) `CHK("chanOrder", (i < 4) ? 4'd0 : (i < 8) ? 4'd3 : 4'd10, chans[i])
        `CHK("acqLen", 8, lastAcq)
        rd("res0", ADDR_RESULT0, 32'h001);
        rd("res3", ADDR_RESULT0 + 8'h0c, 32'h301);
        `CHK("readClear", 1'b1, results_ready_n)
        rd("res10", ADDR_RESULT0 + 8'h28, 32'ha01);
        rd("modeBack", ADDR_MODE, 32'h0);
        // Inhibit active high stalls acquisition
        starts = 0;
        sample_inhibit_in <= 1'b1;
        wr(ADDR_SETUP, 32'h088);
        wr(ADDR_HOST_MASK, 32'h100);
        wr(ADDR_MODE, MODE_HOST);
        repeat (100) @(posedge sys_clk);
        `CHK("inhibited", 0, starts)
        sample_inhibit_in <= 1'b0;
        wait_lvl(1'b0, 500);
        `CHK("released", 1, starts)
        rd("single", ADDR_RESULT0 + 8'h0c, 32'h300);
        sample_inhibit_in <= 1'b1;
        // Settle 256, policy 1, repeat every 1024
        starts = 0;
        wr(ADDR_SETUP, 32'h051);
        repeat (4) @(posedge sys_clk);
        `CHK("idlePower", 2'b00, {convCtrl.adcPowerUp, convCtrl.refPowerUp})
        wr(ADDR_MODE, MODE_HOST);
        n = 0;
        while (starts == 0 && n < 1000) begin @(negedge sys_clk); n++; end
        `CHK("settleSpan", 1'b1, n >= 256 && n <= 300)
        wait_lvl(1'b0, 1000);
        `CHK("postSettle", 1'b1, n >= 256)
        wait_lvl(1'b1, 1200);
        `CHK("timerSpan", 1'b1, n >= 1000 && n <= 1100)
        wait_lvl(1'b0, 1500);
        rd("timedRead", ADDR_RESULT0 + 8'h0c, 32'h300);
        wr(ADDR_MODE, 32'h0);
        // Touch-started sequence over all channels
        wr(ADDR_SETUP, 32'h080);
        wr(ADDR_MODE, MODE_TOUCH);
        touch_alert_n <= 1'b0;
        wait_lvl(1'b0, 1000);
        rd("touchRes", ADDR_RESULT0 + 8'h28, 32'ha03);
        touch_alert_n <= 1'b1;
        wr(ADDR_MODE, 32'h0);
        final_report;
    end
endmodule : acsq_sequencer_tb
